/* File: src/dma_status_regs.sv */
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// [R01] Jabber expiry sets bit 3, aborts, stops transmit, marks descriptor jabber flag.
// [R02] Host-owned next descriptor sets bit 2 and suspends transmit.
// [R03] Host resumes suspended transmit by handing back descriptor and poll demand.
// [R04] Bit 1 sets whenever transmit process enters stopped.
// [R05] Bit 0 sets on frame completion when first descriptor asked for interrupt.
// [R06] Fatal bus error type shows in bits 25:23: parity, master, target abort.
// [R07] After parity error the device stays disabled until software reset.
// [R08] Bits 22:20 report transmit state: stopped, fetch, wait end, read buffer.
// [R09] Transmit codes: setup, suspended, closing; code four is reserved.
// [R10] Bits 19:17 report receive state: stopped, fetch, check end, wait packet.
// [R11] Receive codes: suspended, closing, flushing, queuing frame into buffer.
// [R12] Bits 0 to 16 clear on writing one; writing zero has no effect.
// [R13] Writes to bits 17 to 25 are ignored.
// [R14] Bit 15 is the OR of unmasked abnormal event flags.
// [R15] Transmit-complete flag setting clears the early transmit flag.
// [R16] Event flags stay set until software writes one to clear.
module dma_status_regs
  import dma_status_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_wr,
  output logic [31:0]      wb_dat_rd,
  output logic             wb_ack,
  // Transmit engine events
  input  wire logic        tx_jabber_expire,
  input  wire logic        tx_desc_host_owned,
  input  wire logic        tx_underflow,
  input  wire logic        tx_frame_done,
  input  wire logic        tx_first_desc_ioc,
  input  wire logic        tx_fifo_loaded,
  input  wire logic        tx_poll_demand,
  input  wire logic        tx_phase_valid,
  input  wire logic [2:0]  tx_phase,
  // Receive engine events
  input  wire logic        rx_frame_done,
  input  wire logic        rx_buf_unavail,
  input  wire logic        rx_stop_entry,
  input  wire logic        rx_watchdog,
  input  wire logic        rx_first_buf_full,
  input  wire logic [2:0]  rx_state,
  // Other sources
  input  wire logic        gp_timer_expire,
  input  wire logic        bus_err,
  input  wire logic [2:0]  bus_err_type,
  // Controls to the engines
  output logic             tx_abort,
  output logic             tx_jabber_mark,
  output logic             tx_suspend,
  output logic             bus_disable,
  output logic             sw_reset,
  output logic             irq
);

  typedef struct packed {
    logic [16:0] ev;
    logic [16:0] msk;
    logic [2:0]  err_code;
    logic [2:0]  rx_state;
    logic        bus_off;
    logic        ack;
    logic [31:0] rdat;
    logic        irq;
    logic        tx_abort;
    logic        jab_mark;
    logic        tx_suspend;
    logic        sw_rst;
  } regs_s;

  regs_s r_ff;
  regs_s nxt_r;

  logic [2:0] tx_state;
  logic       tx_stop_entry;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [16:0] low_field(input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] m;
    m = d & lane_mask(sel);
    low_field = m[16:0];
  endfunction

  // ------------------------------------------------------------------
  // Transmit process state
  // ------------------------------------------------------------------
  tx_process_tracker u_tx_trk (
    .clock           (clock),
    .srst            (srst),
    .sw_rst          (r_ff.sw_rst),
    .jabber_expire   (tx_jabber_expire),
    .desc_host_owned (tx_desc_host_owned),
    .underflow       (tx_underflow),
    .poll_demand     (tx_poll_demand),
    .phase_valid     (tx_phase_valid),
    .phase           (tx_phase),
    .state           (tx_state),
    .stop_entry      (tx_stop_entry)
  );

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  logic        req;
  logic        wr_status;
  logic        wr_mask;
  logic        wr_mode;
  logic [16:0] set_v;
  logic [16:0] clr_v;
  logic [16:0] unmasked;
  logic [31:0] lane_m;

  always_comb begin
    nxt_r     = r_ff;
    req       = wb_cyc && wb_stb && !r_ff.ack;
    wr_status = req && wb_we && (wb_adr == STATUS_OFS);
    wr_mask   = req && wb_we && (wb_adr == INT_MASK_OFS);
    wr_mode   = req && wb_we && (wb_adr == BUS_MODE_OFS);
    set_v     = '0;
    clr_v     = '0;
    unmasked  = r_ff.ev & r_ff.msk;
    lane_m    = lane_mask(wb_sel);

    // Bus handshake: ack one cycle after the request, for one cycle
    nxt_r.ack  = req;
    nxt_r.rdat = ZERO_WORD;
    if (req && !wb_we) begin
      unique case (wb_adr)
        STATUS_OFS: begin
          nxt_r.rdat = {STATUS_RST[31:26], r_ff.err_code, tx_state, r_ff.rx_state, r_ff.ev};
        end
        INT_MASK_OFS: begin
          nxt_r.rdat = {15'h0000, r_ff.msk};
        end
        default: begin
          nxt_r.rdat = ZERO_WORD;
        end
      endcase
    end

    // Event sources
    set_v[TX_JAB_BIT]   = tx_jabber_expire;                        // [R01]
    set_v[TX_UNAV_BIT]  = tx_desc_host_owned;                      // [R02]
    set_v[TX_STOP_BIT]  = tx_stop_entry;                           // [R04]
    set_v[TX_DONE_BIT]  = tx_frame_done && tx_first_desc_ioc;      // [R05]
    set_v[TX_UNF_BIT]   = tx_underflow;
    set_v[TX_EARLY_BIT] = tx_fifo_loaded;
    set_v[RX_DONE_BIT]  = rx_frame_done;
    set_v[RX_UNAV_BIT]  = rx_buf_unavail;
    set_v[RX_STOP_BIT]  = rx_stop_entry;
    set_v[RX_WDT_BIT]   = rx_watchdog;
    set_v[GP_TMR_BIT]   = gp_timer_expire;
    set_v[FATAL_BIT]    = bus_err;
    set_v[RX_EARLY_BIT] = rx_first_buf_full;
    set_v[ABN_SUM_BIT]  = |(unmasked & ABN_GROUP);                 // [R14]
    set_v[NRM_SUM_BIT]  = |(unmasked & NRM_GROUP);

    // Write-one-to-clear on bits 0..16 only; upper fields never written
    if (wr_status) begin
      clr_v = low_field(wb_dat_wr, wb_sel);                        // [R12] [R13]
    end
    // Completion supersedes the early indications
    if (set_v[TX_DONE_BIT]) begin
      clr_v[TX_EARLY_BIT] = 1'b1;                                  // [R15]
    end
    if (set_v[RX_DONE_BIT]) begin
      clr_v[RX_EARLY_BIT] = 1'b1;
    end
    // Set wins over a clear landing in the same cycle
    nxt_r.ev = (r_ff.ev & ~clr_v) | set_v;                         // [R16]

    if (wr_mask) begin
      nxt_r.msk = (r_ff.msk & ~lane_m[16:0])
                | (wb_dat_wr[16:0] & lane_m[16:0]);
    end

    // Fatal bus error: keep type, cut bus access
    if (bus_err) begin
      nxt_r.err_code = bus_err_type;                               // [R06]
      nxt_r.bus_off  = 1'b1;
    end else if (r_ff.bus_off && clr_v[FATAL_BIT] && r_ff.err_code != ERR_PARITY) begin
      // Aborts may be acknowledged by clearing the flag; parity may not
      nxt_r.bus_off  = 1'b0;                                       // [R07]
    end

    nxt_r.rx_state = rx_state;                                     // [R10] [R11]

    // Engine controls
    nxt_r.tx_abort   = tx_jabber_expire;                           // [R01]
    nxt_r.jab_mark   = tx_jabber_expire;                           // [R01]
    nxt_r.tx_suspend = tx_desc_host_owned || tx_underflow;         // [R02]
    nxt_r.irq        = |unmasked;

    // Software reset: self-clearing, the only way out of a parity error
    nxt_r.sw_rst = wr_mode && wb_sel[0] && wb_dat_wr[SW_RST_BIT];  // [R07]
    if (r_ff.sw_rst) begin
      nxt_r.ev       = '0;
      nxt_r.err_code = ERR_PARITY;
      nxt_r.bus_off  = 1'b0;                                       // [R07]
      nxt_r.irq      = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign wb_dat_rd      = r_ff.rdat;
  assign wb_ack         = r_ff.ack;
  assign tx_abort       = r_ff.tx_abort;
  assign tx_jabber_mark = r_ff.jab_mark;
  assign tx_suspend     = r_ff.tx_suspend;
  assign bus_disable    = r_ff.bus_off;
  assign sw_reset       = r_ff.sw_rst;
  assign irq            = r_ff.irq;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  a_jabber_flag: // [R01]
    assert property (tx_jabber_expire && !r_ff.sw_rst
                     |=> r_ff.ev[TX_JAB_BIT] && tx_abort && tx_jabber_mark)
    else $error("jabber expiry not flagged or not aborted");

  a_unavail_flag: // [R02]
    assert property (tx_desc_host_owned && !r_ff.sw_rst |=> r_ff.ev[TX_UNAV_BIT] && tx_suspend)
    else $error("unavailable descriptor not flagged");

  a_stop_flag: // [R04]
    assert property (tx_stop_entry && !r_ff.sw_rst |=> r_ff.ev[TX_STOP_BIT])
    else $error("transmit stop entry not flagged");

  a_done_flag: // [R05]
    assert property (tx_frame_done && tx_first_desc_ioc && !tx_fifo_loaded && !r_ff.sw_rst
                     |=> r_ff.ev[TX_DONE_BIT] && !r_ff.ev[TX_EARLY_BIT])
    else $error("transmit completion not flagged or early flag kept");

  a_no_ioc_done: // [R05]
    assert property (!r_ff.ev[TX_DONE_BIT] && !(tx_frame_done && tx_first_desc_ioc)
                     |=> !r_ff.ev[TX_DONE_BIT])
    else $error("completion flag set without interrupt request");

  a_err_code: // [R06]
    assert property (bus_err && !r_ff.sw_rst
                     |=> r_ff.err_code == $past(bus_err_type) && bus_disable
                         && r_ff.ev[FATAL_BIT])
    else $error("bus error type not captured");

  a_parity_hold: // [R07]
    assert property (bus_disable && r_ff.err_code == ERR_PARITY && !r_ff.sw_rst
                     |=> bus_disable)
    else $error("parity error recovered without software reset");

  a_swrst_pulse: // [R07]
    assert property (sw_reset |=> !sw_reset && !bus_disable && r_ff.ev == '0)
    else $error("software reset did not clear state");

  a_w1c_clear: // [R12]
    assert property (r_ff.ack && $past(wb_we) && $past(wb_adr) == STATUS_OFS
                     && $past(wb_sel[0]) && $past(wb_dat_wr[TX_JAB_BIT])
                     && !$past(tx_jabber_expire) |-> !r_ff.ev[TX_JAB_BIT])
    else $error("write of one did not clear jabber flag");

  a_sticky_flag: // [R16]
    assert property (r_ff.ev[TX_JAB_BIT] && !wr_status && !r_ff.sw_rst
                     |=> r_ff.ev[TX_JAB_BIT])
    else $error("event flag dropped without a clear");

  a_rx_field: // [R10]
    assert property (!r_ff.sw_rst ##1 1'b1 |-> r_ff.rx_state == $past(rx_state))
    else $error("receive state field not following engine");

  a_field_ro: // [R13]
    assert property (wr_status && !bus_err |=> r_ff.err_code == $past(r_ff.err_code)
                     || $past(r_ff.sw_rst))
    else $error("write changed the error field");

  a_abn_summary: // [R14]
    assert property (|(r_ff.ev & r_ff.msk & ABN_GROUP) && !r_ff.sw_rst
                     |=> r_ff.ev[ABN_SUM_BIT])
    else $error("abnormal summary not raised");

  a_irq_level:
    assert property (!r_ff.sw_rst |=> irq == |($past(r_ff.ev) & $past(r_ff.msk)))
    else $error("interrupt output does not follow unmasked status");

  a_ack_once:
    assert property (wb_ack |=> !wb_ack)
    else $error("acknowledge longer than one cycle");

  a_ack_answer:
    assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("request not acknowledged in the next cycle");

  a_rdat_idle:
    assert property (!wb_ack |-> wb_dat_rd == ZERO_WORD)
    else $error("read data not zero outside acknowledge");

  a_read_status: // [R08]
    assert property (wb_cyc && wb_stb && !wb_ack && !wb_we && wb_adr == STATUS_OFS
                     |=> wb_dat_rd[16:0] == $past(r_ff.ev)
                         && wb_dat_rd[22:20] == $past(tx_state)
                         && wb_dat_rd[31:26] == STATUS_RST[31:26])
    else $error("status read data does not match the register");

  a_zero_keeps: // [R12]
    assert property (r_ff.ev[TX_JAB_BIT] && wr_status && !wb_dat_wr[TX_JAB_BIT]
                     && !r_ff.sw_rst |=> r_ff.ev[TX_JAB_BIT])
    else $error("write of zero cleared the jabber flag");

  a_nrm_summary:
    assert property (|(r_ff.ev & r_ff.msk & NRM_GROUP) && !r_ff.sw_rst
                     |=> r_ff.ev[NRM_SUM_BIT])
    else $error("normal summary not raised");

  a_rx_early_clr:
    assert property (rx_frame_done && !rx_first_buf_full && !r_ff.sw_rst
                     |=> !r_ff.ev[RX_EARLY_BIT])
    else $error("receive completion kept the early receive flag");

  a_swrst_cause: // [R07]
    assert property (sw_reset |-> $past(wr_mode && wb_sel[0] && wb_dat_wr[SW_RST_BIT]))
    else $error("software reset without a bus mode write");

endmodule

/* File: src/dma_status_pkg.sv */
package dma_status_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0]  BUS_MODE_OFS   = 8'h00;
  localparam logic [7:0]  STATUS_OFS     = 8'h04;
  localparam logic [7:0]  INT_MASK_OFS   = 8'h08;
  localparam logic [31:0] STATUS_RST     = 32'hFC000000;
  localparam logic [31:0] ZERO_WORD      = 32'h00000000;

  // ------------------------------------------------------------------
  // Status field positions
  // ------------------------------------------------------------------
  localparam int EV_W        = 17;
  localparam int TX_DONE_BIT = 0;
  localparam int TX_STOP_BIT = 1;
  localparam int TX_UNAV_BIT = 2;
  localparam int TX_JAB_BIT  = 3;
  localparam int TX_UNF_BIT  = 5;
  localparam int RX_DONE_BIT = 6;
  localparam int RX_UNAV_BIT = 7;
  localparam int RX_STOP_BIT = 8;
  localparam int RX_WDT_BIT  = 9;
  localparam int TX_EARLY_BIT = 10;
  localparam int GP_TMR_BIT  = 11;
  localparam int FATAL_BIT   = 13;
  localparam int RX_EARLY_BIT = 14;
  localparam int ABN_SUM_BIT = 15;
  localparam int NRM_SUM_BIT = 16;
  localparam int SW_RST_BIT  = 0;

  // Members of each summary
  localparam logic [16:0] ABN_GROUP = 17'h007AA;
  localparam logic [16:0] NRM_GROUP = 17'h04845;

  // ------------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------------
  localparam logic [2:0] ERR_PARITY   = 3'h0;
  localparam logic [2:0] ERR_MASTER   = 3'h1;
  localparam logic [2:0] ERR_TARGET   = 3'h2;

  localparam logic [2:0] TX_STOPPED   = 3'h0;
  localparam logic [2:0] TX_FETCH     = 3'h1;
  localparam logic [2:0] TX_WAIT_END  = 3'h2;
  localparam logic [2:0] TX_READ_BUF  = 3'h3;
  localparam logic [2:0] TX_RESERVED  = 3'h4;
  localparam logic [2:0] TX_SETUP     = 3'h5;
  localparam logic [2:0] TX_SUSPENDED = 3'h6;
  localparam logic [2:0] TX_CLOSE     = 3'h7;

  localparam logic [2:0] RX_STOPPED   = 3'h0;
  localparam logic [2:0] RX_FETCH     = 3'h1;
  localparam logic [2:0] RX_CHECK_END = 3'h2;
  localparam logic [2:0] RX_WAIT_PKT  = 3'h3;
  localparam logic [2:0] RX_SUSPENDED = 3'h4;
  localparam logic [2:0] RX_CLOSE     = 3'h5;
  localparam logic [2:0] RX_FLUSH     = 3'h6;
  localparam logic [2:0] RX_QUEUE     = 3'h7;

endpackage

/* File: src/tx_process_tracker.sv */
`timescale 1ns/1ps
module tx_process_tracker
  import dma_status_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       sw_rst,
  // Transmit engine reports
  input  wire logic       jabber_expire,
  input  wire logic       desc_host_owned,
  input  wire logic       underflow,
  input  wire logic       poll_demand,
  input  wire logic       phase_valid,
  input  wire logic [2:0] phase,
  // State out
  output logic [2:0]      state,
  output logic            stop_entry
);

  typedef struct packed {
    logic [2:0] state;
    logic       stop_entry;
  } trk_s;

  trk_s trk_ff;
  trk_s nxt_trk;

  // ------------------------------------------------------------------
  // State tracking
  // ------------------------------------------------------------------
  always_comb begin
    nxt_trk = trk_ff;
    if (sw_rst) begin
      nxt_trk.state = TX_STOPPED;
    end else if (jabber_expire) begin
      nxt_trk.state = TX_STOPPED;                                  // [R01]
    end else if (desc_host_owned || underflow) begin
      nxt_trk.state = TX_SUSPENDED;                                // [R02] [R09]
    end else if (trk_ff.state == TX_SUSPENDED && poll_demand) begin
      nxt_trk.state = TX_FETCH;                                    // [R03]
    end else if (phase_valid && phase != TX_RESERVED) begin
      nxt_trk.state = phase;                                       // [R08] [R09]
    end
    nxt_trk.stop_entry = (nxt_trk.state == TX_STOPPED) && (trk_ff.state != TX_STOPPED);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      trk_ff <= '0;
    end else begin
      trk_ff <= nxt_trk;
    end
  end

  assign state      = trk_ff.state;
  assign stop_entry = trk_ff.stop_entry;

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  a_jabber_stops:
    assert property (jabber_expire && !sw_rst |=> state == TX_STOPPED) // [R01]
    else $error("jabber expiry did not stop the transmit process");

  a_unavail_suspends:
    assert property ((desc_host_owned || underflow) && !jabber_expire && !sw_rst
                     |=> state == TX_SUSPENDED)                         // [R02]
    else $error("transmit process not suspended");

  a_no_reserved:
    assert property (state != TX_RESERVED)                              // [R09]
    else $error("reserved transmit state code reported");

endmodule

/* File: dv/host_model.sv */
`timescale 1ns/1ps
module host_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Device side
  input  wire logic       tx_suspend,
  input  wire logic [3:0] dly,
  output logic            tx_poll_demand
);
  logic [4:0] cnt_ff;

  // Owner bit handed back first, poll follows dly+2 cycles after tx_suspend is sampled
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_ff         <= 5'h00;
      tx_poll_demand <= 1'b0;
    end else begin
      tx_poll_demand <= (cnt_ff == 5'h01);
      if (tx_suspend)
        cnt_ff <= {1'b0, dly} + 5'h02;
      else if (cnt_ff != 5'h00)
        cnt_ff <= cnt_ff - 5'h01;
    end
  end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb
  import dma_status_pkg::*;
;
  logic        clock, srst, cyc, stb, we, ack, ioc, sw_seen;
  logic [7:0]  adr;
  logic [3:0]  sel, dly;
  logic [31:0] wdat, rdat, rd;
  logic [13:0] ev;
  logic [2:0]  tph, rxs, bet, et, xr;
  logic        abort, jmark, susp, bdis, swr, irq, poll;
  logic [15:0] lfsr;
  logic [2:0]  ty[3] = '{ERR_MASTER, ERR_TARGET, ERR_PARITY};
  int          rb[6] = '{6, 7, 8, 9, 14, 11};
  int          error_cnt, num_checks, j;

  dma_status_regs u_dma_status_regs (
    .clock(clock), .srst(srst), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr),
    .wb_sel(sel), .wb_dat_wr(wdat), .wb_dat_rd(rdat), .wb_ack(ack),
    .tx_jabber_expire(ev[0]), .tx_desc_host_owned(ev[1]), .tx_underflow(ev[2]),
    .tx_frame_done(ev[3]), .tx_first_desc_ioc(ioc), .tx_fifo_loaded(ev[4]),
    .tx_poll_demand(poll), .tx_phase_valid(ev[6]), .tx_phase(tph),
    .rx_frame_done(ev[7]), .rx_buf_unavail(ev[8]), .rx_stop_entry(ev[9]),
    .rx_watchdog(ev[10]), .rx_first_buf_full(ev[11]), .rx_state(rxs),
    .gp_timer_expire(ev[12]), .bus_err(ev[13]), .bus_err_type(bet),
    .tx_abort(abort), .tx_jabber_mark(jmark), .tx_suspend(susp), .bus_disable(bdis),
    .sw_reset(swr), .irq(irq));

  host_model u_host_model (
    .clock(clock), .srst(srst), .tx_suspend(susp), .dly(dly), .tx_poll_demand(poll));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) if (swr === 1'b1) sw_seen <= 1'b1;

  // ------------------------------------------------------------------
  // Expectations and checks
  // ------------------------------------------------------------------
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Mask fully open here, so summaries follow their groups
  function automatic logic [31:0] st(input logic [16:0] f, input logic [2:0] t, r, e);
    return {6'h3F, e, t, r, f | {|(f & NRM_GROUP), |(f & ABN_GROUP), 15'h0000}};
  endfunction

  task automatic chk_w(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n == 20) begin
      error_cnt++;
      $display("unexpected at %0t: no ack", $time);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    idle(2);
    wb(1'b0, a, ZERO_WORD);
    chk_w(rd, e);
  endtask

  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
    #1;
  endtask

  // Summaries re-set from flags still set at the clearing edge
  task automatic clr();
    wb(1'b1, STATUS_OFS, 32'h0001FFFF);
    wb(1'b1, STATUS_OFS, 32'h00018000);
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    idle(20000);
    error_cnt++;
    $display("unexpected at %0t: watchdog", $time);
    report_and_stop();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {cyc, stb, we, ioc, sw_seen} = 5'h00;
    {adr, sel, dly, wdat, ev} = '0;
    {tph, rxs, bet, xr} = 12'h000;
    error_cnt = 0;
    num_checks = 0;
    lfsr = 16'h0E2F;
    srst = 1'b1;
    idle(5);
    srst <= 1'b0;
    rdc(STATUS_OFS, STATUS_RST);
    wb(1'b1, STATUS_OFS, 32'hFFFFFFFF);
    rdc(STATUS_OFS, STATUS_RST);
    wb(1'b1, 8'h0C, 32'hFFFFFFFF);
    rdc(8'h0C, ZERO_WORD);
    $display("reset test done");
    wb(1'b0, INT_MASK_OFS, 32'h0001FFFF);
    chk_w(rd, ZERO_WORD);
    wb(1'b1, INT_MASK_OFS, 32'h0001FFFF);
    rdc(INT_MASK_OFS, 32'h0001FFFF);
    tph <= TX_FETCH;
    pulse(6);
    pulse(0);
    chk_b(abort, 1'b1);
    chk_b(jmark, 1'b1);
    rdc(STATUS_OFS, st(17'h0000A, TX_STOPPED, xr, 3'h0));
    chk_b(irq, 1'b1);
    wb(1'b1, STATUS_OFS, 32'h00000008);
    rdc(STATUS_OFS, st(17'h08002, TX_STOPPED, xr, 3'h0));
    clr();
    rdc(STATUS_OFS, STATUS_RST);
    chk_b(irq, 1'b0);
    $display("jabber test done");
    dly <= 4'hF;
    pulse(1);
    chk_b(susp, 1'b1);
    rdc(STATUS_OFS, st(17'h00004, TX_SUSPENDED, xr, 3'h0));
    idle(20);
    wb(1'b0, STATUS_OFS, ZERO_WORD);
    chk_w({29'h0, rd[22:20]}, {29'h0, TX_FETCH});
    dly <= 4'h0;
    pulse(2);
    chk_b(susp, 1'b1);
    clr();
    $display("suspend test done");
    tph <= TX_CLOSE;
    pulse(6);
    pulse(4);
    pulse(3);
    rdc(STATUS_OFS, st(17'h00400, TX_CLOSE, xr, 3'h0));
    ioc <= 1'b1;
    pulse(3);
    rdc(STATUS_OFS, st(17'h08001, TX_CLOSE, xr, 3'h0));
    clr();
    et = TX_CLOSE;
    for (int c = 1; c < 8; c++) begin
      if (c == 6) continue;
      tph <= 3'(c);
      pulse(6);
      if (c != 4) et = 3'(c);
      wb(1'b0, STATUS_OFS, ZERO_WORD);
      chk_w({29'h0, rd[22:20]}, {29'h0, et});
    end
    for (int k = 0; k < 12; k++) begin
      lfsr = lfsr_step(lfsr);
      xr = (k < 8) ? 3'(k) : lfsr[2:0];
      rxs <= xr;
      idle(2);
      wb(1'b0, STATUS_OFS, ZERO_WORD);
      chk_w({29'h0, rd[19:17]}, {29'h0, xr});
    end
    $display("state test done");
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_step(lfsr);
      j = lfsr % 6;
      pulse(7 + j);
      rdc(STATUS_OFS, st(17'(1) << rb[j], et, xr, 3'h0));
      clr();
    end
    wb(1'b1, INT_MASK_OFS, ZERO_WORD);
    pulse(10);
    rdc(STATUS_OFS, {6'h3F, 3'h0, et, xr, 17'h00200});
    chk_b(irq, 1'b0);
    wb(1'b1, INT_MASK_OFS, 32'h0001FFFF);
    rdc(STATUS_OFS, st(17'h00200, et, xr, 3'h0));
    chk_b(irq, 1'b1);
    clr();
    $display("event test done");
    for (int k = 0; k < 3; k++) begin
      bet <= ty[k];
      pulse(13);
      idle(1);
      chk_b(bdis, 1'b1);
      wb(1'b0, STATUS_OFS, ZERO_WORD);
      chk_w({29'h0, rd[25:23]}, {29'h0, ty[k]});
      wb(1'b1, STATUS_OFS, 32'h00002000);
      idle(2);
      chk_b(bdis, ty[k] == ERR_PARITY);
    end
    wb(1'b1, BUS_MODE_OFS, 32'h00000001);
    idle(3);
    chk_b(sw_seen, 1'b1);
    chk_b(bdis, 1'b0);
    rdc(STATUS_OFS, st(17'h00002, TX_STOPPED, xr, 3'h0));
    $display("bus error test done");
    report_and_stop();
  end
endmodule
